/* common/demand_curve_cfg.svh */
`ifndef DEMAND_CURVE_CFG_SVH
`define DEMAND_CURVE_CFG_SVH

// ****************************************
// nonvolatile curve storage
// ****************************************
`define DCT_NVM_BASE   6'h20
`define DCT_NVM_LAST   6'h3f
`define DCT_POINTS     32
`define DCT_WORD_W     18
`define DCT_IN_LSB     9
`define DCT_DEMAND_W   9

// ****************************************
// demand range and arithmetic
// ****************************************
`define DCT_FULL       9'h1ff
`define DCT_DIV_STEPS  5'h12

`endif

/* common/demand_curve_pkg.sv */
`default_nettype none

package demand_curve_pkg;

	// ****************************************
	// sequencer states, one-hot
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_DIV  = 4'h4,
		ST_DONE = 4'h8
	} state_type;

	// ****************************************
	// control modes giving the output its meaning
	// ****************************************
	typedef enum logic [1:0] {
		MODE_SPEED  = 2'h0,
		MODE_TORQUE = 2'h1,
		MODE_POWER  = 2'h2,
		MODE_OPEN   = 2'h3
	} ctrl_mode_type;

	// ****************************************
	// all state of the transformer
	// ****************************************
	typedef struct packed {
		state_type     st;
		logic          ready;
		logic          out_valid;
		logic [8:0]    out;
		ctrl_mode_type out_mode;
		ctrl_mode_type mode;
		logic          rd_en;
		logic [5:0]    addr;
		logic [4:0]    idx;
		logic [8:0]    x;
		logic [8:0]    px;
		logic [8:0]    py;
		logic [8:0]    cx;
		logic [8:0]    cy;
		logic          neg;
		logic [8:0]    dx;
		logic [17:0]   num;
		logic [9:0]    rem;
		logic [17:0]   quo;
		logic [4:0]    cnt;
		logic          interp;
	} core_type;

endpackage

`default_nettype wire

/* rtl/demand_curve_transformer.sv */
`include "demand_curve_cfg.svh"
`default_nettype none

// Summary of operation
// - curve words live at nvm addresses 32..63
// - 9-bit unsigned demand in, 9-bit out
// - same mapping in every control mode
// - open loop: 511 means full motor supply
// - closed loop: 511 means configured range maximum
// - corners stored, between them linear interpolation
// - word: input upper nine, output lower nine
// - first input of 511 ends the curve
// - up to 32 corner points
// - disabled: identity curve, input passes through
module demand_curve_transformer #(
	parameter int unsigned POINTS = `DCT_POINTS
) (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rstn,
	// demand request
	input  wire logic                          demand_valid,
	input  wire logic [8:0]                    demand_in,
	input  wire demand_curve_pkg::ctrl_mode_type ctrl_mode,
	input  wire logic                          map_enable,
	output var  logic                          demand_ready,
	// mapped demand
	output var  logic                          demand_out_valid,
	output var  logic [8:0]                    demand_out,
	output var  demand_curve_pkg::ctrl_mode_type demand_out_mode,
	// nonvolatile memory read port
	output var  logic                          nvm_rd_en,
	output var  logic [5:0]                    nvm_addr,
	input  wire logic [`DCT_WORD_W-1:0]        nvm_rd_data
);

	// ****************************************
	// field decoding
	// ****************************************

	// input demand of a corner word
	function automatic logic [8:0] in_field(input logic [`DCT_WORD_W-1:0] w);
		in_field = w[`DCT_WORD_W-1:`DCT_IN_LSB];
	endfunction

	// output demand of a corner word
	function automatic logic [8:0] out_field(input logic [`DCT_WORD_W-1:0] w);
		out_field = w[`DCT_IN_LSB-1:0];
	endfunction

	// ****************************************
	// state
	// ****************************************
	demand_curve_pkg::core_type q;
	demand_curve_pkg::core_type d;

	logic [8:0]  w_in;
	logic [8:0]  w_out;
	logic        consume;
	logic [9:0]  shifted;
	logic [9:0]  sum;

	// current word and the cycle it is valid in
	assign w_in    = in_field(nvm_rd_data);
	assign w_out   = out_field(nvm_rd_data);
	assign consume = (q.st == demand_curve_pkg::ST_WAIT) && !q.rd_en;

	// ****************************************
	// next state
	// ****************************************

	// sequencer, search and divider
	always_comb begin
		d           = q;
		d.out_valid = 1'b0;
		d.rd_en     = 1'b0;
		d.interp    = 1'b0;
		shifted     = '0;
		sum         = '0;
		unique case (q.st)
			demand_curve_pkg::ST_IDLE: begin
				if (demand_valid) begin
					d.x    = demand_in;
					d.mode = ctrl_mode;
					if (!map_enable) begin
						// identity curve (0,0)-(511,511)
						d.out       = demand_in;
						d.out_mode  = ctrl_mode;
						d.out_valid = 1'b1;
					end else begin
						d.idx   = '0;
						d.px    = '0;
						d.py    = '0;
						d.rd_en = 1'b1;
						d.addr  = `DCT_NVM_BASE;
						d.st    = demand_curve_pkg::ST_WAIT;
					end
				end
			end
			demand_curve_pkg::ST_WAIT: begin
				if (consume) begin
					d.cx = w_in;
					d.cy = w_out;
					if (q.idx == '0 && q.x <= w_in) begin
						// below the first corner: hold its output
						d.out       = w_out;
						d.out_mode  = q.mode;
						d.out_valid = 1'b1;
						d.st        = demand_curve_pkg::ST_IDLE;
					end else if (q.x == w_in || (q.x < w_in && w_in <= q.px)) begin
						// on a corner, or a malformed falling input
						d.out       = w_out;
						d.out_mode  = q.mode;
						d.out_valid = 1'b1;
						d.st        = demand_curve_pkg::ST_IDLE;
					end else if (q.x < w_in) begin
						// inside the segment: set up the divide
						d.dx  = w_in - q.px;
						d.neg = w_out < q.py;
						d.num = (q.x - q.px) * (w_out < q.py ? q.py - w_out : w_out - q.py);
						d.rem = '0;
						d.quo = '0;
						d.cnt = '0;
						d.st  = demand_curve_pkg::ST_DIV;
					end else if (w_in == `DCT_FULL || q.idx == 5'(POINTS - 1)) begin
						// terminator or table end: later words ignored
						d.out       = w_out;
						d.out_mode  = q.mode;
						d.out_valid = 1'b1;
						d.st        = demand_curve_pkg::ST_IDLE;
					end else begin
						// advance to the next word in address order
						d.px    = w_in;
						d.py    = w_out;
						d.idx   = q.idx + 5'h01;
						d.rd_en = 1'b1;
						d.addr  = `DCT_NVM_BASE + {1'b0, q.idx + 5'h01};
					end
				end
			end
			demand_curve_pkg::ST_DIV: begin
				// restoring divide, one quotient bit per cycle
				shifted = {q.rem[8:0], q.num[17]};
				d.num   = {q.num[16:0], 1'b0};
				if (shifted >= {1'b0, q.dx}) begin
					d.rem = shifted - {1'b0, q.dx};
					d.quo = {q.quo[16:0], 1'b1};
				end else begin
					d.rem = shifted;
					d.quo = {q.quo[16:0], 1'b0};
				end
				d.cnt = q.cnt + 5'h01;
				if (q.cnt == `DCT_DIV_STEPS - 5'h01) begin
					d.st = demand_curve_pkg::ST_DONE;
				end
			end
			demand_curve_pkg::ST_DONE: begin
				// truncated step added to the segment start, clamped
				if (q.neg) begin
					d.out = (q.quo[8:0] > q.py) ? 9'h000 : q.py - q.quo[8:0];
				end else begin
					sum   = {1'b0, q.py} + {1'b0, q.quo[8:0]};
					d.out = sum[9] ? `DCT_FULL : sum[8:0];
				end
				// duty in open loop, fraction of range otherwise
				d.out_mode  = q.mode;
				d.out_valid = 1'b1;
				d.interp    = 1'b1;
				d.st        = demand_curve_pkg::ST_IDLE;
			end
		endcase
		d.ready = (d.st == demand_curve_pkg::ST_IDLE);
	end

	// ****************************************
	// registers
	// ****************************************

	// synchronous active-low reset
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			q       <= '0;
			q.st    <= demand_curve_pkg::ST_IDLE;
			q.ready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign demand_ready     = q.ready;
	assign demand_out_valid = q.out_valid;
	assign demand_out       = q.out;
	assign demand_out_mode  = q.out_mode;
	assign nvm_rd_en        = q.rd_en;
	assign nvm_addr         = q.addr;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	logic [8:0] seg_lo;
	logic [8:0] seg_hi;

	// bounds of the segment just interpolated
	assign seg_lo = (q.py < q.cy) ? q.py : q.cy;
	assign seg_hi = (q.py < q.cy) ? q.cy : q.py;

	property p_addr_window;
		nvm_rd_en |-> (nvm_addr >= `DCT_NVM_BASE) && (nvm_addr <= `DCT_NVM_LAST);
	endproperty
	a_addr_window: assert property (p_addr_window)
		else $error("curve read outside its address window");

	property p_first_addr;
		demand_ready && demand_valid && map_enable
			|=> nvm_rd_en && nvm_addr == `DCT_NVM_BASE;
	endproperty
	a_first_addr: assert property (p_first_addr)
		else $error("search did not start at first curve word");

	property p_ascending;
		nvm_rd_en && $past(q.st == demand_curve_pkg::ST_WAIT)
			|-> nvm_addr == $past(nvm_addr, 2) + 6'h01;
	endproperty
	a_ascending: assert property (p_ascending)
		else $error("curve words not read in ascending order");

	property p_bypass;
		demand_ready && demand_valid && !map_enable
			|=> demand_out_valid && demand_out == $past(demand_in) && demand_ready;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("disabled mapping did not pass demand through");

	property p_terminator;
		consume && w_in == `DCT_FULL |=> !nvm_rd_en;
	endproperty
	a_terminator: assert property (p_terminator)
		else $error("read continued past the terminating point");

	property p_below_first;
		consume && q.idx == 5'h00 && q.x <= w_in
			|=> demand_out_valid && demand_out == $past(w_out);
	endproperty
	a_below_first: assert property (p_below_first)
		else $error("input below first corner not held at its output");

	property p_on_corner;
		consume && q.idx != 5'h00 && q.x == w_in
			|=> demand_out_valid && demand_out == $past(w_out);
	endproperty
	a_on_corner: assert property (p_on_corner)
		else $error("corner input did not give the corner output");

	property p_within_segment;
		demand_out_valid && q.interp |-> demand_out >= seg_lo && demand_out <= seg_hi;
	endproperty
	a_within_segment: assert property (p_within_segment)
		else $error("interpolated output outside its segment");

	property p_latency;
		demand_ready && demand_valid |-> ##[1:120] demand_out_valid;
	endproperty
	a_latency: assert property (p_latency)
		else $error("mapped demand not produced in time");

	property p_mode_kept;
		demand_ready && demand_valid ##1 demand_out_valid
			|-> demand_out_mode == $past(ctrl_mode);
	endproperty
	a_mode_kept: assert property (p_mode_kept)
		else $error("output mode differs from requested mode");

	property p_interp_between;
		q.interp |-> q.x > q.px && q.x < q.cx;
	endproperty
	a_interp_between: assert property (p_interp_between)
		else $error("interpolated input not inside its segment");

	property p_busy_holds;
		!demand_ready |=> $stable(q.x) && $stable(q.mode);
	endproperty
	a_busy_holds: assert property (p_busy_holds)
		else $error("request changed while search was busy");

	property p_read_spacing;
		nvm_rd_en |=> !nvm_rd_en;
	endproperty
	a_read_spacing: assert property (p_read_spacing)
		else $error("curve reads closer than two cycles");

	property p_ready_with_result;
		demand_out_valid |-> demand_ready;
	endproperty
	a_ready_with_result: assert property (p_ready_with_result)
		else $error("result given while still busy");

	property p_table_end;
		consume && q.idx == 5'(POINTS - 1) |=> !nvm_rd_en;
	endproperty
	a_table_end: assert property (p_table_end)
		else $error("read continued past the last curve word");

endmodule

`default_nettype wire

/* testbench/nvm_curve_model.sv */
`default_nettype none

// ****************************************
// nonvolatile curve memory, one-cycle read
// ****************************************
module nvm_curve_model (
	// clock
	input  wire logic        ref_clk,
	// read port
	input  wire logic        nvm_rd_en,
	input  wire logic [5:0]  nvm_addr,
	output var  logic [17:0] nvm_rd_data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [17:0] mem [0:63]; // filled by the bench, indexed by address

	// word valid only the cycle after the read, scrambled otherwise
	always @(posedge ref_clk) begin
		if (nvm_rd_en)
			nvm_rd_data <= mem[nvm_addr];
		else
			nvm_rd_data <= ~nvm_rd_data;
	end
endmodule

`default_nettype wire

/* testbench/demand_curve_transformer_tb.sv */
`default_nettype none

module demand_curve_transformer_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                            ref_clk;
	logic                            rstn;
	logic                            demand_valid;
	logic [8:0]                      demand_in;
	demand_curve_pkg::ctrl_mode_type ctrl_mode;
	logic                            map_enable;
	logic                            demand_ready;
	logic                            demand_out_valid;
	logic [8:0]                      demand_out;
	demand_curve_pkg::ctrl_mode_type demand_out_mode;
	logic                            nvm_rd_en;
	logic [5:0]                      nvm_addr;
	logic [17:0]                     nvm_rd_data;
	int                              mismatches = 0;
	int                              checks_done = 0;
	int                              cycles = 0;

	demand_curve_transformer uut (.ref_clk(ref_clk), .rstn(rstn), .demand_valid(demand_valid),
		.demand_in(demand_in), .ctrl_mode(ctrl_mode), .map_enable(map_enable),
		.demand_ready(demand_ready), .demand_out_valid(demand_out_valid),
		.demand_out(demand_out), .demand_out_mode(demand_out_mode),
		.nvm_rd_en(nvm_rd_en), .nvm_addr(nvm_addr), .nvm_rd_data(nvm_rd_data));

	nvm_curve_model nvm (.ref_clk(ref_clk), .nvm_rd_en(nvm_rd_en), .nvm_addr(nvm_addr),
		.nvm_rd_data(nvm_rd_data));

	// ****************************************
	// clock, timeout, read address watch
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
		if (rstn === 1'b1 && nvm_rd_en === 1'b1)
			check({17'h0, nvm_addr >= 6'h20}, 18'h1);
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// words after the list stay erased
	task automatic load(input logic [17:0] w0, w1, w2, w3);
		for (int i = 4; i < 32; i++)
			nvm.mem[32 + i] = 18'h3ffff;
		nvm.mem[32] = w0;
		nvm.mem[33] = w1;
		nvm.mem[34] = w2;
		nvm.mem[35] = w3;
	endtask

	// one request, held one cycle longer with other data while busy
	task automatic run(input logic [8:0] x, input logic [1:0] m, input logic en,
			input logic [8:0] exp);
		int n;
		@(posedge ref_clk) #1;
		demand_valid = 1'b1;
		demand_in = x;
		ctrl_mode = demand_curve_pkg::ctrl_mode_type'(m);
		map_enable = en;
		@(posedge ref_clk) #1;
		n = 1;
		if (en)
			demand_in = ~x;
		while (demand_out_valid !== 1'b1 && n < 200) begin
			@(posedge ref_clk) #1;
			n++;
			if (n == 2)
				demand_valid = 1'b0;
		end
		if (n == 1)
			demand_valid = 1'b0;
		check({9'h0, demand_out}, {9'h0, exp});
		check({16'h0, demand_out_mode}, {16'h0, m});
		check({17'h0, n <= (en ? 85 : 1)}, 18'h1);
		check({17'h0, demand_ready}, 18'h1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_bypass();
		for (int m = 0; m < 4; m++) begin
			run(9'h000, m[1:0], 1'b0, 9'h000);
			run(9'h1ff, m[1:0], 1'b0, 9'h1ff);
			run(9'h0a7, m[1:0], 1'b0, 9'h0a7);
		end
	endtask

	task automatic test_rising();
		load({9'd0, 9'd0}, {9'd200, 9'd100}, {9'd511, 9'd511}, 18'h3ffff);
		run(9'd100, 2'h0, 1'b1, 9'd50);
		run(9'd200, 2'h1, 1'b1, 9'd100);
		run(9'd350, 2'h2, 1'b1, 9'd298);
		run(9'd511, 2'h3, 1'b1, 9'd511);
	endtask

	task automatic test_falling();
		load({9'd100, 9'd400}, {9'd300, 9'd100}, {9'd511, 9'd511}, 18'h3ffff);
		run(9'd50, 2'h0, 1'b1, 9'd400);
		run(9'd200, 2'h1, 1'b1, 9'd250);
		run(9'd250, 2'h2, 1'b1, 9'd175);
		run(9'd301, 2'h3, 1'b1, 9'd101);
	endtask

	task automatic test_early_end();
		load({9'd0, 9'd0}, {9'd511, 9'd77}, {9'd0, 9'd500}, {9'd511, 9'd9});
		run(9'd400, 2'h0, 1'b1, 9'd60);
		run(9'd511, 2'h3, 1'b1, 9'd77);
	endtask

	task automatic test_full_table();
		for (int i = 0; i < 31; i++)
			nvm.mem[32 + i] = {9'(16 * i), 9'(8 * i)};
		nvm.mem[63] = {9'd511, 9'd511};
		run(9'd100, 2'h1, 1'b1, 9'd50);
		run(9'd495, 2'h2, 1'b1, 9'd371);
	endtask

	// reset cuts a long search, then a fresh request
	task automatic test_reset_midway();
		@(posedge ref_clk) #1;
		demand_valid = 1'b1;
		demand_in = 9'd495;
		ctrl_mode = demand_curve_pkg::MODE_POWER;
		map_enable = 1'b1;
		@(posedge ref_clk) #1;
		demand_valid = 1'b0;
		repeat (30) @(posedge ref_clk);
		#1;
		rstn = 1'b0;
		@(posedge ref_clk) #1;
		check({6'h0, demand_ready, demand_out_valid, nvm_rd_en, demand_out}, 18'h00800);
		check({12'h0, nvm_addr}, 18'h00000);
		rstn = 1'b1;
		run(9'd100, 2'h1, 1'b1, 9'd50);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		demand_valid = 1'b0;
		demand_in = 9'h000;
		ctrl_mode = demand_curve_pkg::MODE_SPEED;
		map_enable = 1'b0;
		repeat (20) @(posedge ref_clk);
		#1;
		check({15'h0, demand_ready, demand_out_valid, nvm_rd_en}, 18'h4);
		rstn = 1'b1;
		test_bypass();
		test_rising();
		test_falling();
		test_early_end();
		test_full_table();
		test_reset_midway();
		tally_and_finish();
	end
endmodule

`default_nettype wire
